// ===== design/tprc_top.sv
// timer, prescaler, event counter and reset control logic
`timescale 1ns/1ps
module tprc_top #(
  parameter int WDT_BITS = 8  // watchdog counter width
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 power_on,         // supply power-on pulse
  input  wire logic                 supply_low_n,     // voltage detector, active low
  input  wire logic                 detector_option,  // option: use detector reset
  input  wire logic                 ext_reset_n,      // external reset pin
  input  wire logic                 wdt_enable,       // watchdog enabled
  input  wire logic                 run_mode,         // green or normal mode
  input  wire logic                 main_clk_en,      // main clock enabled
  input  wire logic                 tick_32k,         // 32768 Hz tick
  input  wire logic                 tick_main,        // main clock tick
  input  wire logic                 tmr_src_tick,     // timer source tick
  input  wire logic                 wdt_src_tick,     // watchdog source tick
  input  wire logic                 gie,              // global interrupt on
  input  wire logic                 port9_wake,       // port 9 external input
  input  wire logic [7:0]           irq_src,          // interrupt sources, high level idle
  input  wire tprc_pkg::tprc_iow_t  iow,
  input  wire tprc_pkg::tprc_instr_t instr,
  output logic [7:0]                ioc_rdata,        // selected register readback
  output logic [7:0]                timer_count,
  output logic [7:0]                control_register,
  output logic [7:0]                interrupt_flag_register,
  output logic [7:0]                cfg_page1,
  output logic [7:0]                interrupt_mask_register,
  output logic                      lcd_common_count_sel,
  output logic                      pin6_open_drain_en,
  output logic                      pin7_open_drain_en,
  output logic                      irq_fetch,        // fetch from interrupt vector
  output logic                      sys_reset,        // device reset request
  output logic                      osc_run,          // oscillator kept running
  output logic [11:0]               pc_load,          // vector to load
  output logic                      power_up_clear,   // clear status/indirect upper bits
  output logic                      asleep
);
  // storage
  logic [7:0]          cfg_page0;
  logic [7:0]          ctr_a, ctr_b;
  logic [7:0]          psc;
  logic [6:0]          ctr_a_div;
  logic [WDT_BITS-1:0] wdt;
  logic [7:0]          src_q;
  logic                ovf_a_q, ovf_b_q, tmr_ovf_q;
  logic [7:0]          next_cfg_page0, next_cfg_page1, next_mask, next_ctl, next_flag;
  logic [7:0]          next_ctr_a, next_ctr_b, next_psc, next_tmr;
  logic [6:0]          next_ctr_a_div;
  logic [WDT_BITS-1:0] next_wdt;
  logic                next_asleep, next_irq_fetch, next_ovf_a, next_ovf_b, next_tmr_ovf;
  logic [7:0]          next_rdata;
  logic                tick_a, tick_b, step_a, prescaler_assign_bit, psc_tick, wdt_timeout;
  logic                next_sys_reset, next_power_up_clear;
  tprc_pkg::tprc_cause_t cause;
  logic [7:0]          div_mask;

  // source selection, each tick a single-cycle strobe so switching adds no edge
  always_comb
  begin
    tick_a   = cfg_page1[tprc_pkg::CFG_C1S_BIT] ? (tick_main & main_clk_en) : tick_32k;
    tick_b   = cfg_page1[tprc_pkg::CFG_C2S_BIT] ? (tick_main & main_clk_en) : tick_32k;
    div_mask = (8'h01 << cfg_page1[tprc_pkg::CFG_PSC_LSB +: 3]) - 8'h01;
    step_a   = tick_a && ((ctr_a_div & div_mask[6:0]) == div_mask[6:0]);
    prescaler_assign_bit      = control_register[tprc_pkg::CTL_PAB_BIT];
    // prescaler ratio in control bits 2:0, serving only the assigned user
    psc_tick = prescaler_assign_bit ? wdt_src_tick : tmr_src_tick;
  end

  // reset cause selection
  always_comb
  begin
    wdt_timeout = wdt_enable && run_mode && (&wdt) && wdt_src_tick && !asleep;
    if (!ext_reset_n)
      cause = tprc_pkg::TPRC_RST_PIN;
    else if (power_on || (detector_option && !supply_low_n))
      cause = tprc_pkg::TPRC_RST_SUPPLY;
    else if (wdt_timeout)
      cause = tprc_pkg::TPRC_RST_WDT;
    else
      cause = tprc_pkg::TPRC_RST_NONE;
    next_sys_reset      = (cause != tprc_pkg::TPRC_RST_NONE);
    next_power_up_clear = (cause == tprc_pkg::TPRC_RST_SUPPLY);
  end

  // next values for registers, counters and flags
  always_comb
  begin
    next_cfg_page0 = cfg_page0;
    next_cfg_page1 = cfg_page1;
    next_mask      = interrupt_mask_register;
    next_ctl       = control_register;
    next_flag      = interrupt_flag_register;
    next_ctr_a     = ctr_a;
    next_ctr_b     = ctr_b;
    next_ctr_a_div = ctr_a_div;
    next_psc       = psc;
    next_tmr       = timer_count;
    next_wdt       = wdt;
    next_asleep    = asleep;
    next_ovf_a     = 1'b0;
    next_ovf_b     = 1'b0;
    next_tmr_ovf   = 1'b0;
    // event counter a: prescaled up-count
    if (tick_a)
      next_ctr_a_div = ctr_a_div + 7'h01;
    if (step_a)
    begin
      next_ctr_a     = ctr_a + 8'h01;
      next_ctr_a_div = 7'h00;
      next_ovf_a     = (ctr_a == 8'hFF);
    end
    // event counter b: always 1:1
    if (tick_b)
    begin
      next_ctr_b = ctr_b + 8'h01;
      next_ovf_b = (ctr_b == 8'hFF);
    end
    // shared prescaler
    if (psc_tick)
    begin
      next_psc = psc + 8'h01;
      if ((psc & ((8'h02 << control_register[2:0]) - 8'h01)) ==
          ((8'h02 << control_register[2:0]) - 8'h01))
      begin
        next_psc = 8'h00;
        if (prescaler_assign_bit)
          next_wdt = wdt + 1'b1;
        else
        begin
          next_tmr     = timer_count + 8'h01;
          next_tmr_ovf = (timer_count == 8'hFF);
        end
      end
    end
    if (instr.wdt_clr || instr.sleep)
    begin
      next_wdt = '0;
      if (prescaler_assign_bit)
        next_psc = 8'h00;
      // with prescaler on the timer, sleep leaves it alone
    end
    if (instr.sleep)
      next_asleep = 1'b1;
    if (instr.tmr_wr)
    begin
      next_tmr = instr.tmr_data;
      next_psc = 8'h00;
    end
    if (instr.ctl_wr)
      next_ctl = instr.ctl_data;
    // register writes through the i/o control path
    if (iow.wr)
      unique case (iow.addr)
        tprc_pkg::IOC_CFG:
          if (iow.page)
            next_cfg_page1 = iow.data;
          else
            next_cfg_page0 = iow.data;
        tprc_pkg::IOC_MASK:
          next_mask = iow.data & tprc_pkg::MASK_WMASK;
        tprc_pkg::IOC_CTR1:
          if (iow.page)
            next_ctr_a = iow.data;
        tprc_pkg::IOC_CTR2:
          if (iow.page)
            next_ctr_b = iow.data;
        default:
          next_ctl = next_ctl;
      endcase
    // software clear first, so a same-cycle hardware set wins
    if (instr.flag_wr)
      next_flag = instr.flag_data;
    for (int i = 0; i < 8; i++)
      if (interrupt_mask_register[i] && src_q[i] && !irq_src[i] && i != tprc_pkg::IRQ_UNUSED)
        next_flag[i] = 1'b1;
    if (interrupt_mask_register[tprc_pkg::IRQ_CTR1] && ovf_a_q)
    begin
      next_flag[tprc_pkg::IRQ_CTR1] = 1'b1;
      next_ctr_a = 8'h00;
    end
    if (interrupt_mask_register[tprc_pkg::IRQ_CTR2] && ovf_b_q)
    begin
      next_flag[tprc_pkg::IRQ_CTR2] = 1'b1;
      next_ctr_b = 8'h00;
    end
    if (interrupt_mask_register[tprc_pkg::IRQ_TMR] && tmr_ovf_q)
      next_flag[tprc_pkg::IRQ_TMR] = 1'b1;
    // wake-up from sleep
    if (asleep && (port9_wake || (wdt_enable && (&wdt) && wdt_src_tick)))
    begin
      next_asleep                   = 1'b0;
      next_flag[tprc_pkg::IRQ_WAKE] = 1'b1;
    end
    next_irq_fetch = gie && |(next_flag & interrupt_mask_register);
    // readback
    unique case (iow.addr)
      tprc_pkg::IOC_CFG:  next_rdata = iow.page ? cfg_page1 : cfg_page0;
      tprc_pkg::IOC_MASK: next_rdata = interrupt_mask_register;
      tprc_pkg::IOC_CTR1: next_rdata = iow.page ? ctr_a : 8'h00;
      tprc_pkg::IOC_CTR2: next_rdata = iow.page ? ctr_b : 8'h00;
      default:            next_rdata = 8'h00;
    endcase
  end

  // register stage
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cfg_page0               <= tprc_pkg::CFG_RESET;
      cfg_page1               <= tprc_pkg::CFG_RESET;
      interrupt_mask_register <= tprc_pkg::MASK_RESET;
      interrupt_flag_register <= tprc_pkg::FLAG_RESET;
      control_register        <= tprc_pkg::CTL_RESET;
      psc                     <= 8'h00;
      wdt                     <= '0;
      ctr_a                   <= 8'h00;
      ctr_b                   <= 8'h00;
      ctr_a_div               <= 7'h00;
      timer_count             <= 8'h00;
      src_q                   <= 8'hFF;
      ovf_a_q                 <= 1'b0;
      ovf_b_q                 <= 1'b0;
      tmr_ovf_q               <= 1'b0;
      asleep                  <= 1'b0;
      irq_fetch               <= 1'b0;
      ioc_rdata               <= 8'h00;
      sys_reset               <= 1'b1;
      power_up_clear          <= 1'b1;
      osc_run                 <= 1'b1;
      pc_load                 <= tprc_pkg::RESET_VECTOR;
      lcd_common_count_sel    <= 1'b0;
      pin6_open_drain_en      <= 1'b0;
      pin7_open_drain_en      <= 1'b0;
    end
    else if (next_sys_reset)
    begin
      // internal reset causes reinitialise as a pin reset does
      cfg_page0               <= tprc_pkg::CFG_RESET;
      cfg_page1               <= tprc_pkg::CFG_RESET;
      interrupt_mask_register <= tprc_pkg::MASK_RESET;
      interrupt_flag_register <= tprc_pkg::FLAG_RESET;
      control_register        <= tprc_pkg::CTL_RESET;
      psc                     <= 8'h00;
      wdt                     <= '0;
      ctr_a                   <= 8'h00;
      ctr_b                   <= 8'h00;
      ctr_a_div               <= 7'h00;
      timer_count             <= 8'h00;
      src_q                   <= irq_src;
      ovf_a_q                 <= 1'b0;
      ovf_b_q                 <= 1'b0;
      tmr_ovf_q               <= 1'b0;
      asleep                  <= 1'b0;
      irq_fetch               <= 1'b0;
      ioc_rdata               <= 8'h00;
      sys_reset               <= 1'b1;
      power_up_clear          <= next_power_up_clear;
      osc_run                 <= 1'b1;
      pc_load                 <= tprc_pkg::RESET_VECTOR;
      lcd_common_count_sel    <= 1'b0;
      pin6_open_drain_en      <= 1'b0;
      pin7_open_drain_en      <= 1'b0;
    end
    else
    begin
      cfg_page0               <= next_cfg_page0;
      cfg_page1               <= next_cfg_page1;
      interrupt_mask_register <= next_mask;
      interrupt_flag_register <= next_flag;
      control_register        <= next_ctl;
      psc                     <= next_psc;
      wdt                     <= next_wdt;
      ctr_a                   <= next_ctr_a;
      ctr_b                   <= next_ctr_b;
      ctr_a_div               <= next_ctr_a_div;
      timer_count             <= next_tmr;
      src_q                   <= irq_src;
      ovf_a_q                 <= next_ovf_a;
      ovf_b_q                 <= next_ovf_b;
      tmr_ovf_q               <= next_tmr_ovf;
      asleep                  <= next_asleep;
      irq_fetch               <= next_irq_fetch;
      ioc_rdata               <= next_rdata;
      sys_reset               <= 1'b0;
      power_up_clear          <= 1'b0;
      osc_run                 <= !next_asleep;
      pc_load                 <= next_irq_fetch ? tprc_pkg::IRQ_VECTOR : tprc_pkg::RESET_VECTOR;
      lcd_common_count_sel    <= next_cfg_page1[tprc_pkg::CFG_LCD_BIT];
      pin6_open_drain_en      <= next_cfg_page1[tprc_pkg::CFG_OD6_BIT];
      pin7_open_drain_en      <= next_cfg_page1[tprc_pkg::CFG_OD7_BIT];
    end
  end
endmodule : tprc_top

// ===== design/tprc_pkg.sv
// package of constants and carriers for the timer, prescaler and reset control block
// Notes on behaviour
// - event_counter_a prescale codes divide by 1 to 128
// - event_counter_a source: 32768 Hz or enabled main
// - event_counter_b source likewise, always 1:1 scale
// - common-count bit picks eight or four commons
// - bits 6 and 7 enable open-drain pins
// - mask register read/write, bit 6 unused
// - one prescaler serves timer or watchdog only
// - timer write loads timer, clears prescaler
// - watchdog-clear and sleep clear watchdog prescaler
// - sleep keeps prescaler when assigned to timer
// - reset from pin, supply, or watchdog timeout
// - option adds detector supply reset to power-on reset
// - reset runs oscillator, program counter zero
// - power-up clears status and indirect upper bits
// - reset clears watchdog, prescaler; wdt_enable is an input, left as driven
// - reset sets control register to all ones
// - reset clears flags, mask, both config pages
// - wake on watchdog or port input, flag set
// - falling edge of enabled source sets flag
// - event counters preset, read, restart after interrupt
// - enabled interrupt fetches from address 008H
package tprc_pkg;
  // configuration page 1 field positions
  localparam int CFG_LCD_BIT  = 0;
  localparam int CFG_PSC_LSB  = 1;
  localparam int CFG_C1S_BIT  = 4;
  localparam int CFG_C2S_BIT  = 5;
  localparam int CFG_OD6_BIT  = 6;
  localparam int CFG_OD7_BIT  = 7;
  // control register field positions
  localparam int CTL_PAB_BIT  = 3;
  // interrupt flag and mask positions
  localparam int IRQ_TMR      = 0;
  localparam int IRQ_CTR1     = 4;
  localparam int IRQ_CTR2     = 5;
  localparam int IRQ_UNUSED   = 6;
  localparam int IRQ_WAKE     = 6;
  // reset values and the mask register write mask
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET  = 8'hFF;
  localparam logic [7:0] MASK_WMASK = 8'hBF;
  // vectors
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] IRQ_VECTOR   = 12'h008;
  // i/o control register numbers used by the core
  localparam logic [3:0] IOC_CFG  = 4'hE;
  localparam logic [3:0] IOC_MASK = 4'hF;
  localparam logic [3:0] IOC_CTR1 = 4'hB;
  localparam logic [3:0] IOC_CTR2 = 4'hC;
  // core access to i/o control registers
  typedef struct packed {
    logic       wr;    // one-cycle write strobe
    logic [3:0] addr;  // control register number
    logic       page;  // page select
    logic [7:0] data;  // write data
  } tprc_iow_t;
  // instruction strobes from the decoder
  typedef struct packed {
    logic       tmr_wr;     // write to timer
    logic [7:0] tmr_data;   // timer write data
    logic       ctl_wr;     // write to control register
    logic [7:0] ctl_data;   // control write data
    logic       wdt_clr;    // watchdog clear instruction
    logic       sleep;      // sleep instruction
    logic       flag_wr;    // write to flag register
    logic [7:0] flag_data;  // flag write data
  } tprc_instr_t;
  // reset causes
  typedef enum logic [1:0] {
    TPRC_RST_NONE,
    TPRC_RST_PIN,
    TPRC_RST_SUPPLY,
    TPRC_RST_WDT
  } tprc_cause_t;
endpackage : tprc_pkg

// ===== bench/tprc_chk.sv
// concurrent checks on the timer, prescaler and reset control ports
`timescale 1ns/1ps
module tprc_chk (
  input wire logic                 mclk,
  input wire logic                 reset,
  input wire logic                 power_on,
  input wire logic                 supply_low_n,
  input wire logic                 detector_option,
  input wire logic                 ext_reset_n,
  input wire logic                 gie,
  input wire tprc_pkg::tprc_iow_t  iow,
  input wire tprc_pkg::tprc_instr_t instr,
  input wire logic [7:0]           timer_count,
  input wire logic [7:0]           control_register,
  input wire logic [7:0]           interrupt_flag_register,
  input wire logic [7:0]           cfg_page1,
  input wire logic [7:0]           interrupt_mask_register,
  input wire logic                 lcd_common_count_sel,
  input wire logic                 pin6_open_drain_en,
  input wire logic                 pin7_open_drain_en,
  input wire logic                 irq_fetch,
  input wire logic                 sys_reset,
  input wire logic                 osc_run,
  input wire logic [11:0]          pc_load,
  input wire logic                 power_up_clear,
  input wire logic                 asleep
);
  // one clock domain, async reset masks every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // config page 1 write lands next cycle, common-count output follows bit 0
  AST_CFG_WR: assert property (iow.wr && iow.addr == tprc_pkg::IOC_CFG && iow.page |=>
    cfg_page1 == $past(iow.data) && lcd_common_count_sel == $past(iow.data[0]))
    else $error("config write not applied");
  // page 0 write goes to config page 0, page 1 untouched
  AST_CFG_PAGE0: assert property (iow.wr && iow.addr == tprc_pkg::IOC_CFG && !iow.page
    && ext_reset_n |=> $stable(cfg_page1)) else $error("page 0 write changed config");
  // open-drain enables mirror config bits 6 and 7
  AST_OPEN_DRAIN: assert property (pin6_open_drain_en == cfg_page1[6]
    && pin7_open_drain_en == cfg_page1[7]) else $error("open-drain enable wrong");
  // mask write keeps bit 6 clear
  AST_MASK_WR: assert property (iow.wr && iow.addr == tprc_pkg::IOC_MASK |=>
    interrupt_mask_register == ($past(iow.data) & 8'hBF)) else $error("mask write wrong");
  AST_MASK_B6: assert property (!interrupt_mask_register[6])
    else $error("mask bit 6 set");
  // timer write loads the count
  AST_TMR_WR: assert property (instr.tmr_wr && ext_reset_n && !power_on |=>
    timer_count == $past(instr.tmr_data)) else $error("timer write wrong");
  // pin reset reinitialises the registers
  AST_PIN_RST: assert property (!ext_reset_n |=> sys_reset && control_register == 8'hFF
    && cfg_page1 == 8'h00 && interrupt_mask_register == 8'h00
    && interrupt_flag_register == 8'h00) else $error("pin reset values wrong");
  // supply causes raise the power-up clear
  AST_PWR_ON: assert property (power_on |=> sys_reset && power_up_clear)
    else $error("power-on reset missing");
  AST_DETECT: assert property (detector_option && !supply_low_n |=> sys_reset
    && power_up_clear) else $error("detector reset missing");
  // reset keeps the oscillator and loads vector zero
  AST_RST_VEC: assert property (sys_reset |-> osc_run && pc_load == 12'h000)
    else $error("reset vector wrong");
  // pending enabled flag with interrupts on fetches from the vector
  AST_FETCH: assert property ((gie && |(interrupt_flag_register & interrupt_mask_register))
    [*2] |-> irq_fetch) else $error("interrupt fetch missing");
  AST_NO_FETCH: assert property (!gie [*2] |-> !irq_fetch)
    else $error("fetch with interrupts off");
  // main scenarios reached
  COV_FETCH: cover property (irq_fetch);
  COV_PIN: cover property (!ext_reset_n ##1 sys_reset);
  COV_WAKE: cover property ($fell(asleep));
endmodule : tprc_chk
bind tprc_top tprc_chk u_chk (.mclk(mclk), .reset(reset), .power_on(power_on),
  .supply_low_n(supply_low_n), .detector_option(detector_option), .ext_reset_n(ext_reset_n),
  .gie(gie), .iow(iow), .instr(instr), .timer_count(timer_count),
  .control_register(control_register), .interrupt_flag_register(interrupt_flag_register),
  .cfg_page1(cfg_page1), .interrupt_mask_register(interrupt_mask_register),
  .lcd_common_count_sel(lcd_common_count_sel), .pin6_open_drain_en(pin6_open_drain_en),
  .pin7_open_drain_en(pin7_open_drain_en), .irq_fetch(irq_fetch), .sys_reset(sys_reset),
  .osc_run(osc_run), .pc_load(pc_load), .power_up_clear(power_up_clear), .asleep(asleep));

// ===== bench/testbench.sv
// directed testbench for the timer, prescaler and reset control block
`timescale 1ns/1ps
module testbench;
  logic mclk, reset, power_on, supply_low_n, detector_option, ext_reset_n;
  logic wdt_enable, run_mode, main_clk_en, gie, port9_wake;
  logic [3:0]  tk;          // 32k, main, timer, watchdog ticks
  logic [7:0]  irq_src;     // interrupt sources, idle high
  logic [7:0]  rd, ioc_rdata, timer_count, control_register, flags, cfg_page1, mask;
  logic        lcd, od6, od7, irq_fetch, sys_reset, osc_run, puc, asleep;
  logic [11:0] pc_load;
  logic        seen_rst, seen_puc;  // sticky reset observations
  tprc_pkg::tprc_iow_t   iow;
  tprc_pkg::tprc_instr_t instr;
  int bad_count, n_tests, cycles;
  tprc_top #(.WDT_BITS(4)) dut (.mclk(mclk), .reset(reset), .power_on(power_on),
    .supply_low_n(supply_low_n), .detector_option(detector_option),
    .ext_reset_n(ext_reset_n), .wdt_enable(wdt_enable), .run_mode(run_mode),
    .main_clk_en(main_clk_en), .tick_32k(tk[0]), .tick_main(tk[1]), .tmr_src_tick(tk[2]),
    .wdt_src_tick(tk[3]), .gie(gie), .port9_wake(port9_wake), .irq_src(irq_src),
    .iow(iow), .instr(instr), .ioc_rdata(ioc_rdata), .timer_count(timer_count),
    .control_register(control_register), .interrupt_flag_register(flags),
    .cfg_page1(cfg_page1), .interrupt_mask_register(mask), .lcd_common_count_sel(lcd),
    .pin6_open_drain_en(od6), .pin7_open_drain_en(od7), .irq_fetch(irq_fetch),
    .sys_reset(sys_reset), .osc_run(osc_run), .pc_load(pc_load), .power_up_clear(puc),
    .asleep(asleep));
  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // sticky reset flags and hang guard
  always @(posedge mclk)
  begin
    if (sys_reset) seen_rst <= 1'b1;
    if (puc) seen_puc <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  // compare one value
  task check(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // control register write, one-cycle strobe
  task io_wr(input logic [3:0] a, input logic p, input logic [7:0] d);
    @(posedge mclk) iow <= {1'b1, a, p, d};
    @(posedge mclk) iow.wr <= 1'b0;
    #1;
  endtask : io_wr
  // readback appears one cycle after the address
  task io_rd(input logic [3:0] a, input logic p, output logic [7:0] d);
    @(posedge mclk) iow <= {1'b0, a, p, 8'h00};
    @(posedge mclk);
    #1 d = ioc_rdata;
  endtask : io_rd
  // instruction strobes: 10 timer, 08 control, 04 wdt clear, 02 sleep, 01 flag
  task strobe(input logic [4:0] s, input logic [7:0] d);
    @(posedge mclk) instr <= {s[4], d, s[3], d, s[2], s[1], s[0], d};
    @(posedge mclk) instr <= '0;
    #1;
  endtask : strobe
  // n single-cycle ticks on one source
  task tick_n(input int s, input int n);
    repeat (n)
    begin
      @(posedge mclk) tk[s] <= 1'b1;
      @(posedge mclk) tk <= 4'h0;
    end
    #1;
  endtask : tick_n
  // one-cycle reset cause: 0 pin, 1 detector, 2 power-on
  task cause(input int k);
    seen_rst = 1'b0;
    seen_puc = 1'b0;
    @(posedge mclk)
    begin
      ext_reset_n <= (k != 0);
      supply_low_n <= (k != 1);
      power_on <= (k == 2);
    end
    @(posedge mclk) {ext_reset_n, supply_low_n, power_on} <= 3'b110;
    cyc(2);
  endtask : cause
  task finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // main sequence
  initial
  begin
    {reset, power_on, supply_low_n, detector_option, ext_reset_n} = 5'b10101;
    {wdt_enable, run_mode, main_clk_en, gie, port9_wake} = 5'b01100;
    {tk, irq_src, iow, instr} = {4'h0, 8'hFF, 14'h0000, 29'h0};
    {bad_count, n_tests, cycles} = '0;
    {seen_rst, seen_puc} = 2'b00;
    cyc(3);
    check("cfg", cfg_page1, 8'h00);
    check("mask", mask, 8'h00);
    check("flags", flags, 8'h00);
    check("control", control_register, 8'hFF);
    check("rst", {osc_run, sys_reset, puc, 9'h000}, 12'hE00);
    check("pc", pc_load, 12'h000);
    @(posedge mclk) reset <= 1'b0;
    cyc(2);
    check("rst_off", sys_reset, 1'b0);
    io_wr(4'hE, 1'b1, 8'hC1);
    check("pins", {lcd, od6, od7}, 3'b111);
    io_rd(4'hE, 1'b1, rd);
    check("cfg_rd", rd, 8'hC1);
    io_wr(4'hE, 1'b1, 8'h00);
    check("pins0", {lcd, od6, od7}, 3'b000);
    io_wr(4'hE, 1'b0, 8'h5A);
    check("page0", cfg_page1, 8'h00);
    io_wr(4'hF, 1'b0, 8'hFF);
    io_rd(4'hF, 1'b0, rd);
    check("mask_rd", rd, 8'hBF);
    io_rd(4'h3, 1'b0, rd);
    check("unmapped", rd, 8'h00);
    // every divider code: two full periods give two steps
    for (int c = 0; c < 8; c++)
    begin
      io_wr(4'hE, 1'b1, 8'(c << 1));
      io_wr(4'hB, 1'b1, 8'h00);
      tick_n(0, 2 << c);
      io_rd(4'hB, 1'b1, rd);
      check("ctr_a_div", rd, 8'h02);
    end
    io_wr(4'hE, 1'b1, 8'h10);
    io_wr(4'hB, 1'b1, 8'h00);
    tick_n(0, 3);
    tick_n(1, 3);
    io_rd(4'hB, 1'b1, rd);
    check("ctr_a_main", rd, 8'h03);
    io_wr(4'hE, 1'b1, 8'h2E);
    io_wr(4'hC, 1'b1, 8'h00);
    tick_n(1, 2);
    io_rd(4'hC, 1'b1, rd);
    check("ctr_b", rd, 8'h02);
    io_wr(4'hC, 1'b1, 8'hFF);
    gie <= 1'b1;
    tick_n(1, 1);
    cyc(3);
    check("ovf_flag", flags & 8'h20, 8'h20);
    check("fetch", irq_fetch, 1'b1);
    check("vector", pc_load, 12'h008);
    io_rd(4'hC, 1'b1, rd);
    check("ctr_b_wrap", rd, 8'h00);
    gie <= 1'b0;
    strobe(5'h01, 8'h00);
    irq_src <= 8'hFD;
    cyc(3);
    check("pin_flag", flags, 8'h02);
    strobe(5'h01, 8'h00);
    io_wr(4'hF, 1'b0, 8'h00);
    irq_src <= 8'hFF;
    cyc(2);
    irq_src <= 8'hFD;
    cyc(3);
    check("masked", flags & 8'h02, 8'h00);
    // timer with prescaler ratio 2
    strobe(5'h08, 8'h00);
    strobe(5'h10, 8'h00);
    tick_n(2, 1);
    strobe(5'h10, 8'h00);
    tick_n(2, 1);
    check("tmr_clr", timer_count, 8'h00);
    tick_n(2, 1);
    check("tmr_step", timer_count, 8'h01);
    tick_n(2, 1);
    strobe(5'h02, 8'h00);
    check("asleep", asleep, 1'b1);
    @(posedge mclk) port9_wake <= 1'b1;
    @(posedge mclk) port9_wake <= 1'b0;
    cyc(2);
    check("woken", asleep, 1'b0);
    check("wake_flag", flags & 8'h40, 8'h40);
    tick_n(2, 1);
    check("tmr_keep", timer_count, 8'h02);
    // watchdog on the prescaler
    strobe(5'h08, 8'h08);
    wdt_enable <= 1'b1;
    seen_rst = 1'b0;
    repeat (6)
    begin
      tick_n(3, 8);
      strobe(5'h04, 8'h00);
    end
    check("wdt_clr", seen_rst, 1'b0);
    tick_n(3, 80);
    check("wdt_rst", seen_rst, 1'b1);
    check("ctl_ones", control_register, 8'hFF);
    wdt_enable <= 1'b0;
    io_wr(4'hF, 1'b0, 8'h11);
    cause(0);
    check("pin_rst", {seen_rst, seen_puc}, 2'b10);
    check("mask_clr", mask, 8'h00);
    cause(1);
    check("det_off", seen_rst, 1'b0);
    detector_option <= 1'b1;
    cause(1);
    check("det_on", {seen_rst, seen_puc}, 2'b11);
    cause(2);
    check("pwr_on", {seen_rst, seen_puc}, 2'b11);
    finish_test();
  end
endmodule : testbench
